// ### design/pcs_core.sv
// pcs_core: program counter sequencing and hardware return stack.
// assumes the decoder issues one op per cycle on op_valid with its operands.
//
// Our own choice: the APB register port.
`timescale 1ns/1ps
// How it works
// [R1] the 15-bit counter low byte is a read/write register
// [R2] counter bits 14:8 are not accessible; they come from the high latch
// [R3] any reset clears the whole counter to zero
// [R4] writing the low byte also loads bits 14:8 from the high latch
// [R5] call loads bits 10:0 from operand and 14:11 from latch bits 6:3
// [R6] computed call loads low byte from accumulator, high bits from latch
// [R7] accumulator branch sets counter to next address plus unsigned accumulator
// [R8] operand branch sets counter to next address plus signed operand
// [R9] sixteen by fifteen-bit return stack outside program and data space
// [R10] calls and interrupt vectoring push; all three returns pop
// [R11] push and pop leave the high latch unchanged
// [R12] with fault reset off the stack wraps circularly
// [R13] overflow and underflow flags set whether or not fault reset is on
// [R14] five-bit stack pointer exposed with top-of-stack high and low
// [R15] push increments then stores; return restores then decrements
// [R16] with fault reset on, overflow or underflow resets and flags power control
// [R17] otherwise the counter advances by one per fetch
module pcs_core
  import pcs_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [pcs_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // decoder side
  input wire logic op_valid,
  input wire logic [3:0] op_code,
  input wire logic [pcs_pkg::OPW-1:0] op_operand,
  input wire logic [7:0] accum,
  input wire logic [7:0] low_wdata,
  input wire logic [pcs_pkg::PC_W-1:0] int_vector,
  // configuration strap and outputs
  input wire logic stack_fault_reset_en,
  output logic [pcs_pkg::PC_W-1:0] pc,
  output logic [pcs_pkg::PC_W-1:0] pop_pc,
  output logic stack_fault_reset,
  output logic stack_over_flag,
  output logic stack_under_flag,
  output logic irq
);
  import pcs_pkg::*;

  logic [7:0] counter_high_latch;
  logic [SP_W-1:0] stack_pointer_reg;
  logic [PC_W-1:0] tos_rdata;
  logic [1:0] status;
  logic [1:0] mask;
  logic irq_int;

  // apb decode
  wire setup = psel && !penable;
  wire wr = psel && penable && pwrite;
  wire rd_en = psel && !pwrite;
  wire hit_sp = (paddr == ADDR_SP);
  wire hit_top_of_stack_low = (paddr == ADDR_TOP_OF_STACK_LOW);
  wire hit_top_of_stack_high = (paddr == ADDR_TOP_OF_STACK_HIGH);
  wire hit_pcl = (paddr == ADDR_PCL);
  wire hit_lath = (paddr == ADDR_COUNTER_HIGH_LATCH);
  wire hit_ctrl = (paddr == ADDR_CTRL);
  wire hit_stat = (paddr == ADDR_STAT);
  wire hit_mask = (paddr == ADDR_MASK);
  wire mapped = hit_sp | hit_top_of_stack_low | hit_top_of_stack_high | hit_pcl | hit_lath | hit_ctrl | hit_stat | hit_mask;

  // op decode
  wire do_call = op_valid && (op_code == OP_CALL);
  wire do_ccall = op_valid && (op_code == OP_CCALL);
  wire do_int = op_valid && (op_code == OP_INTVEC);
  wire do_pop = op_valid && (op_code == OP_RET || op_code == OP_RETLIT || op_code == OP_RETINT);
  wire do_push = do_call | do_ccall | do_int; // see [R10]
  wire do_wrlow = op_valid && (op_code == OP_WRLOW);

  // pointer movement; the stored index is the low four bits, bit 4 marks empty
  wire [SP_W-1:0] sp_inc = stack_pointer_reg + 5'h01; // see [R15]
  wire [SP_W-1:0] sp_dec = stack_pointer_reg - 5'h01;
  wire overflow = do_push && (stack_pointer_reg == 5'h0F); // see [R13]
  wire underflow = do_pop && (stack_pointer_reg == SP_RESET); // see [R13]
  wire [SP_W-1:0] sp_push = (stack_pointer_reg == 5'h0F) ? 5'h00 : sp_inc; // see [R12]
  wire [SP_W-1:0] sp_pop = (stack_pointer_reg == 5'h00) ? SP_RESET : sp_dec;
  wire fault = stack_fault_reset_en && (overflow || underflow); // see [R16]

  // write port of the stack: push stores the address after the current one
  wire [PC_W-1:0] next_seq = pc + 15'h0001; // see [R17]
  wire [PC_W-1:0] push_val = next_seq; // calls and interrupts both resume after pc
  wire sw_tos_we = wr && (hit_top_of_stack_low || hit_top_of_stack_high);
  wire [PC_W-1:0] sw_tos_val = hit_top_of_stack_low ? {tos_rdata[14:8], pwdata[7:0]}
                                        : {pwdata[6:0], tos_rdata[7:0]};
  wire stk_we = (do_push && !fault) || sw_tos_we;
  wire [3:0] stk_waddr = do_push ? sp_push[3:0] : stack_pointer_reg[3:0];
  wire [PC_W-1:0] stk_wdata = do_push ? push_val : sw_tos_val;

  pcs_stack #(.DEPTH(DEPTH), .W(PC_W)) u_stack ( // see [R9]
    .pclk(pclk),
    .presetn(presetn),
    .we(stk_we),
    .waddr(stk_waddr),
    .wdata(stk_wdata),
    .raddr(stack_pointer_reg[3:0]),
    .rdata(tos_rdata)
  );

  // top of stack reads zero when empty and fault reset is on
  wire tos_zero = stack_fault_reset_en && stack_pointer_reg[4];
  wire [PC_W-1:0] tos_view = tos_zero ? '0 : tos_rdata; // see [R14]

  // next program counter selection
  wire [PC_W-1:0] abr_target = next_seq + {7'h00, accum}; // see [R7]
  wire [PC_W-1:0] obr_target = next_seq + {{6{op_operand[8]}}, op_operand[8:0]}; // see [R8]
  wire [PC_W-1:0] call_target = {counter_high_latch[6:3], op_operand}; // see [R5]
  wire [PC_W-1:0] ccall_target = {counter_high_latch[6:0], accum}; // see [R6]
  wire [PC_W-1:0] wrlow_target = {counter_high_latch[6:0], low_wdata}; // see [R4]
  wire [PC_W-1:0] swlow_target = {counter_high_latch[6:0], pwdata[7:0]};
  logic [PC_W-1:0] next_pc;
  always_comb begin
    next_pc = pc;
    if (wr && hit_pcl) next_pc = swlow_target; // see [R1]
    else if (op_valid) begin
      unique case (op_code)
        OP_FETCH: next_pc = next_seq;
        OP_CALL: next_pc = call_target;
        OP_CCALL: next_pc = ccall_target;
        OP_ABRANCH: next_pc = abr_target;
        OP_OBRANCH: next_pc = obr_target;
        OP_RET, OP_RETLIT, OP_RETINT: next_pc = tos_view; // see [R15]
        OP_INTVEC: next_pc = int_vector;
        OP_WRLOW: next_pc = wrlow_target;
        default: next_pc = pc;
      endcase
    end
  end

  // next stack pointer: software write, push or pop
  logic [SP_W-1:0] next_sp;
  always_comb begin
    next_sp = stack_pointer_reg;
    if (wr && hit_sp) next_sp = pwdata[SP_W-1:0];
    else if (do_push) next_sp = sp_push;
    else if (do_pop) next_sp = sp_pop;
  end

  // counter and pointer; a fault forces the reset image instead
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc <= '0; // see [R3]
      stack_pointer_reg <= SP_RESET;
      stack_fault_reset <= 1'b0;
    end else if (fault) begin
      pc <= '0; // see [R3]
      stack_pointer_reg <= SP_RESET;
      stack_fault_reset <= 1'b1; // see [R16]
    end else begin
      pc <= next_pc;
      stack_pointer_reg <= next_sp;
      stack_fault_reset <= 1'b0;
    end
  end

  // high latch is software-only; stack traffic never touches it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      counter_high_latch <= 8'h00;
    end else if (wr && hit_lath) begin
      counter_high_latch <= {1'b0, pwdata[6:0]}; // see [R11]
    end
  end

  // returned address for the decoder, registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) pop_pc <= '0;
    else if (do_pop) pop_pc <= tos_view;
  end

  // sticky flags in the power control image; write one clears, set wins
  pcs_irq #(.N(2)) u_irq (
    .pclk(pclk),
    .presetn(presetn),
    .event_in({underflow, overflow}), // see [R13]
    .clear((wr && hit_stat) ? pwdata[1:0] : 2'b00),
    .mask_wdata(pwdata[1:0]),
    .mask_we(wr && hit_mask),
    .status(status),
    .mask(mask),
    .irq(irq_int)
  );
  assign stack_over_flag = status[ST_OVF];
  assign stack_under_flag = status[ST_UNF];
  assign irq = irq_int;

  // read mux; the high counter bits have no read path
  logic [31:0] rmux;
  always_comb begin
    rmux = 32'h0000_0000;
    if (hit_sp) rmux = {27'h0, stack_pointer_reg}; // see [R14]
    else if (hit_top_of_stack_low) rmux = {24'h0, tos_view[7:0]};
    else if (hit_top_of_stack_high) rmux = {25'h0, tos_view[14:8]};
    else if (hit_pcl) rmux = {24'h0, pc[7:0]}; // see [R2]
    else if (hit_lath) rmux = {24'h0, counter_high_latch};
    else if (hit_ctrl) rmux = {31'h0, stack_fault_reset_en};
    else if (hit_stat) rmux = {30'h0, status};
    else if (hit_mask) rmux = {30'h0, mask};
  end

  // apb answers in the access cycle after setup (no wait states)
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      pslverr <= setup && !mapped;
      prdata <= (setup && rd_en) ? rmux : 32'h0000_0000;
    end
  end
endmodule : pcs_core

// ### design/pcs_pkg.sv
// pcs_pkg: shared constants for the program counter and return stack block.
// assumes an APB slave with 32-bit data; register offsets are byte addresses.
package pcs_pkg;
  localparam int PC_W = 15;
  localparam int SP_W = 5;
  localparam int DEPTH = 16;
  localparam int OPW = 11;
  // instruction-level operation codes from the decoder
  localparam logic [3:0] OP_FETCH = 4'h0;
  localparam logic [3:0] OP_CALL = 4'h1;
  localparam logic [3:0] OP_CCALL = 4'h2;
  localparam logic [3:0] OP_ABRANCH = 4'h3;
  localparam logic [3:0] OP_OBRANCH = 4'h4;
  localparam logic [3:0] OP_RET = 4'h5;
  localparam logic [3:0] OP_RETLIT = 4'h6;
  localparam logic [3:0] OP_RETINT = 4'h7;
  localparam logic [3:0] OP_INTVEC = 4'h8;
  localparam logic [3:0] OP_WRLOW = 4'h9;
  localparam logic [3:0] OP_HOLD = 4'hA;
  // bus address width: the stack registers sit at four times a twelve-bit index
  localparam int ADDR_W = 14;
  // register indices; the byte address is the index times four
  localparam logic [11:0] IDX_SP = 12'hFED;
  localparam logic [11:0] IDX_TOP_OF_STACK_LOW = 12'hFEE;
  localparam logic [11:0] IDX_TOP_OF_STACK_HIGH = 12'hFEF;
  localparam logic [13:0] ADDR_SP = {IDX_SP, 2'h0};
  localparam logic [13:0] ADDR_TOP_OF_STACK_LOW = {IDX_TOP_OF_STACK_LOW, 2'h0};
  localparam logic [13:0] ADDR_TOP_OF_STACK_HIGH = {IDX_TOP_OF_STACK_HIGH, 2'h0};
  localparam logic [13:0] ADDR_PCL = 14'h0000;
  localparam logic [13:0] ADDR_COUNTER_HIGH_LATCH = 14'h0004;
  localparam logic [13:0] ADDR_CTRL = 14'h0008;
  localparam logic [13:0] ADDR_STAT = 14'h000C;
  localparam logic [13:0] ADDR_MASK = 14'h0010;
  localparam logic [4:0] SP_RESET = 5'h1F;
  localparam logic [14:0] VECTOR = 15'h0004;
  // status bit positions
  localparam int ST_OVF = 0;
  localparam int ST_UNF = 1;
endpackage : pcs_pkg

// ### design/pcs_stack.sv
// pcs_stack: sixteen-entry return address storage in flip-flops.
// assumes the controller gives the index; a read in a write cycle returns the old entry.
`timescale 1ns/1ps
module pcs_stack #(
  parameter int DEPTH = 16,
  parameter int W = 15
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // write port
  input wire logic we,
  input wire logic [$clog2(DEPTH)-1:0] waddr,
  input wire logic [W-1:0] wdata,
  // read port
  input wire logic [$clog2(DEPTH)-1:0] raddr,
  output logic [W-1:0] rdata
);
  logic [W-1:0] mem [DEPTH];
  // storage clears on reset so reads of unused slots are defined
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < DEPTH; i++) mem[i] <= '0;
    end else if (we) begin
      mem[waddr] <= wdata;
    end
  end
  assign rdata = mem[raddr];
endmodule : pcs_stack

// ### design/pcs_irq.sv
// pcs_irq: sticky event bits with mask and a level interrupt output.
// assumes one-cycle event pulses; write-one clears, a new event wins.
`timescale 1ns/1ps
module pcs_irq #(
  parameter int N = 2
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // events and software access
  input wire logic [N-1:0] event_in,
  input wire logic [N-1:0] clear,
  input wire logic [N-1:0] mask_wdata,
  input wire logic mask_we,
  // state
  output logic [N-1:0] status,
  output logic [N-1:0] mask,
  output logic irq
);
  wire [N-1:0] next_status = (status & ~clear) | event_in;
  // set beats clear so no event is lost in a clearing cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status <= '0;
      mask <= '0;
      irq <= 1'b0;
    end else begin
      status <= next_status;
      if (mask_we) mask <= mask_wdata;
      irq <= |(next_status & (mask_we ? mask_wdata : mask));
    end
  end
endmodule : pcs_irq

// ### test/pcs_chk.sv
// pcs_chk: port-level checks on the counter and return stack block.
// assumes a bind onto pcs_core; one clock, async active-low reset.
`timescale 1ns/1ps
module pcs_chk
  import pcs_pkg::*;
(
  // clock, reset and bus
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [pcs_pkg::ADDR_W-1:0] paddr,
  input wire logic pready,
  // decoder side and results
  input wire logic op_valid,
  input wire logic [3:0] op_code,
  input wire logic [pcs_pkg::OPW-1:0] op_operand,
  input wire logic [7:0] accum,
  input wire logic [7:0] low_wdata,
  input wire logic [pcs_pkg::PC_W-1:0] int_vector,
  input wire logic stack_fault_reset_en,
  input wire logic [pcs_pkg::PC_W-1:0] pc,
  input wire logic [pcs_pkg::PC_W-1:0] pop_pc,
  input wire logic stack_fault_reset,
  input wire logic stack_over_flag
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // a software low-byte write wins, and a fault reset overrides any target
  wire logic pcl_wr = psel && penable && pwrite && paddr == ADDR_PCL;
  wire logic go = op_valid && !pcl_wr && !stack_fault_reset_en;
  wire logic st_wr = psel && pwrite && paddr == ADDR_STAT;
  wire logic [14:0] soff = {{6{op_operand[8]}}, op_operand[8:0]};
  wire logic [14:0] uacc = {7'h00, accum};
  // one-deep memory of the latest push; a pop or software stack write forgets it
  wire logic push_op = op_valid && !stack_fault_reset_en
                       && (op_code == OP_CALL || op_code == OP_CCALL || op_code == OP_INTVEC);
  wire logic ret_op = op_valid
                      && (op_code == OP_RET || op_code == OP_RETLIT || op_code == OP_RETINT);
  wire logic stk_sw = psel && penable && pwrite
                      && (paddr == ADDR_SP || paddr == ADDR_TOP_OF_STACK_LOW || paddr == ADDR_TOP_OF_STACK_HIGH);
  logic push_fresh;
  logic [14:0] last_push;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      push_fresh <= 1'b0;
      last_push <= 15'h0000;
    end else if (push_op && !stk_sw) begin
      push_fresh <= 1'b1;
      last_push <= pc + 15'h0001;
    end else if (push_op || ret_op || stk_sw || stack_fault_reset_en) begin
      push_fresh <= 1'b0;
    end
  end
  property p_fetch;
    go && op_code == OP_FETCH |=> pc == $past(pc) + 15'h0001;
  endproperty
  a_fetch: assert property (p_fetch) else $error("fetch did not step");
  property p_wrlow;
    go && op_code == OP_WRLOW |=> pc[7:0] == $past(low_wdata);
  endproperty
  a_wrlow: assert property (p_wrlow) else $error("low byte not loaded");
  property p_call;
    go && op_code == OP_CALL |=> pc[10:0] == $past(op_operand);
  endproperty
  a_call: assert property (p_call) else $error("call target wrong");
  property p_ccall;
    go && op_code == OP_CCALL |=> pc[7:0] == $past(accum);
  endproperty
  a_ccall: assert property (p_ccall) else $error("computed call wrong");
  property p_abr;
    go && op_code == OP_ABRANCH |=> pc == $past(pc) + 15'h0001 + $past(uacc);
  endproperty
  a_abr: assert property (p_abr) else $error("accum branch wrong");
  property p_obr;
    go && op_code == OP_OBRANCH |=> pc == $past(pc) + 15'h0001 + $past(soff);
  endproperty
  a_obr: assert property (p_obr) else $error("operand branch wrong");
  property p_vec;
    go && op_code == OP_INTVEC |=> pc == $past(int_vector);
  endproperty
  a_vec: assert property (p_vec) else $error("vector not taken");
  property p_pop;
    go && ret_op && push_fresh |=> pc == $past(last_push) && pop_pc == $past(last_push);
  endproperty
  a_pop: assert property (p_pop) else $error("return not restored");
  property p_fault;
    stack_fault_reset |-> pc == 15'h0000 ##1 !stack_fault_reset;
  endproperty
  a_fault: assert property (p_fault) else $error("fault reset wrong");
  property p_sticky;
    stack_over_flag && !st_wr |=> stack_over_flag;
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag lost");
  property p_rdy;
    psel && !penable |=> pready;
  endproperty
  a_rdy: assert property (p_rdy) else $error("no ready after setup");
  c_fault: cover property (stack_fault_reset);
  c_ovf: cover property (stack_over_flag);
  c_obr: cover property (go && op_code == OP_OBRANCH);
  c_vec: cover property (go && op_code == OP_INTVEC);
endmodule : pcs_chk
bind pcs_core pcs_chk u_pcs_chk (.*);

// ### test/pcs_dec_model.sv
// pcs_dec_model: stands in for the instruction decoder and interrupt logic.
// assumes the bench calls issue; operand lines carry junk between ops.
`timescale 1ns/1ps
module pcs_dec_model
  import pcs_pkg::*;
(
  // clock
  input wire logic pclk,
  // decoder outputs
  output logic op_valid,
  output logic [3:0] op_code,
  output logic [pcs_pkg::OPW-1:0] op_operand,
  output logic [7:0] accum,
  output logic [7:0] low_wdata,
  output logic [pcs_pkg::PC_W-1:0] int_vector
);
  initial begin
    op_valid = 1'b0;
    op_code = OP_HOLD;
    op_operand = 11'h000;
    accum = 8'h00;
    low_wdata = 8'h00;
    int_vector = 15'h0200;
  end
  // one op for one cycle; inverted lines after it so stale values never help
  task issue(input logic [3:0] c, input logic [10:0] o, input logic [7:0] a);
    @(posedge pclk);
    op_valid <= 1'b1;
    op_code <= c;
    op_operand <= o;
    accum <= a;
    low_wdata <= a;
    @(posedge pclk);
    op_valid <= 1'b0;
    op_code <= OP_HOLD;
    op_operand <= ~o;
    accum <= ~a;
    low_wdata <= ~a;
    #1;
  endtask : issue
endmodule : pcs_dec_model

// ### test/pc_and_hw_stack_tb_top.sv
// pc_and_hw_stack_tb_top: register and op sequences against pcs_core.
// assumes pcs_dec_model on the decoder side; 40 MHz clock.
`timescale 1ns/1ps
module pc_and_hw_stack_tb_top;
  import pcs_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, op_valid, irq;
  logic stack_fault_reset_en, stack_fault_reset, stack_over_flag, stack_under_flag;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] op_code;
  logic [10:0] op_operand;
  logic [7:0] accum, low_wdata;
  logic [14:0] int_vector, pc, pop_pc;
  int failures, n_compared, i;
  pcs_core u_pcs_core (.*);
  pcs_dec_model u_pcs_dec_model (.*);
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // bus master holds the request until pready is seen at an edge
  task apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task op(input logic [3:0] c, input logic [10:0] o, input logic [7:0] a);
    u_pcs_dec_model.issue(c, o, a);
  endtask : op
  task wrap_up;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : wrap_up
  // watchdog: the whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge pclk);
    failures++;
    wrap_up();
  end
  initial begin
    {presetn, psel, penable, pwrite, stack_fault_reset_en} = 5'h00;
    paddr = 14'h0000;
    pwdata = 32'h0;
    failures = 0;
    n_compared = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    chk(pc, 32'h0);
    apb(1'b0, ADDR_SP, 32'h0);
    chk(rd, 32'h1F);
    apb(1'b1, ADDR_COUNTER_HIGH_LATCH, 32'h55);
    op(OP_WRLOW, 11'h000, 8'h34);
    chk(pc, 32'h5534);
    apb(1'b0, ADDR_PCL, 32'h0);
    chk(rd, 32'h34);
    op(OP_FETCH, 11'h000, 8'h00);
    chk(pc, 32'h5535);
    op(OP_CALL, 11'h123, 8'h00);
    chk(pc, 32'h5123);
    apb(1'b0, ADDR_TOP_OF_STACK_LOW, 32'h0);
    chk(rd, 32'h36);
    apb(1'b0, ADDR_TOP_OF_STACK_HIGH, 32'h0);
    chk(rd, 32'h55);
    apb(1'b0, ADDR_COUNTER_HIGH_LATCH, 32'h0);
    chk(rd, 32'h55);
    op(OP_CCALL, 11'h000, 8'h80);
    chk(pc, 32'h5580);
    op(OP_ABRANCH, 11'h000, 8'hFF);
    chk(pc, 32'h5680);
    op(OP_OBRANCH, 11'h1F0, 8'h00);
    chk(pc, 32'h5671);
    op(OP_RET, 11'h000, 8'h00);
    chk(pc, 32'h5124);
    chk(pop_pc, 32'h5124);
    // interrupt vectoring pushes like a call; its return resumes after it
    op(OP_INTVEC, 11'h000, 8'h00);
    chk(pc, 32'h0200);
    op(OP_RETINT, 11'h000, 8'h00);
    chk(pc, 32'h5125);
    op(OP_RETLIT, 11'h000, 8'h00);
    chk(pc, 32'h5536);
    op(OP_RETINT, 11'h000, 8'h00);
    chk(stack_under_flag, 32'h1);
    apb(1'b1, ADDR_MASK, 32'h2);
    apb(1'b0, ADDR_STAT, 32'h0);
    chk(rd, 32'h2);
    chk(irq, 32'h1);
    apb(1'b1, ADDR_MASK, 32'h1);
    apb(1'b0, ADDR_STAT, 32'h0);
    chk(irq, 32'h0);
    apb(1'b1, ADDR_STAT, 32'h2);
    apb(1'b0, ADDR_STAT, 32'h0);
    chk(rd, 32'h0);
    // seventeen pushes with fault reset off wrap onto the first entry
    apb(1'b1, ADDR_SP, 32'h1F);
    for (i = 0; i < 17; i++) begin
      op(OP_WRLOW, 11'h000, i[7:0]);
      op(OP_CALL, 11'h000, 8'h00);
    end
    chk(stack_over_flag, 32'h1);
    apb(1'b0, ADDR_SP, 32'h0);
    chk(rd, 32'h0);
    op(OP_RET, 11'h000, 8'h00);
    chk(pc, 32'h5511);
    // a reset in mid-run clears the counter and the flags again
    @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    chk(pc, 32'h0);
    chk(stack_over_flag, 32'h0);
    apb(1'b1, ADDR_SP, 32'h1F);
    stack_fault_reset_en <= 1'b1;
    op(OP_RET, 11'h000, 8'h00);
    chk(stack_fault_reset, 32'h1);
    chk(pc, 32'h0);
    chk(stack_under_flag, 32'h1);
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk(rd, 32'h1);
    apb(1'b0, 14'h0100, 32'h0);
    chk(err, 32'h1);
    chk(rd, 32'h0);
    wrap_up();
  end
endmodule : pc_and_hw_stack_tb_top
